/* File: logic/mcf_check_unit.sv */
`timescale 1ns/1ps
module mcf_check_unit
  import mcf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire mcf_fault_t fault_in,
  input wire logic mm_exception,
  input wire mcf_cpu_state_t cpu_state,
  input wire logic ack_wr,
  input wire logic [31:0] ack_wdata,
  input wire logic [2:0] frame_rd_idx,
  output logic check_taken,
  output logic double_error_halt,
  output logic check_in_progress,
  output logic recoverable,
  output logic [15:0] check_code,
  output logic va_usable,
  output mcf_frame_t frame_out,
  output logic [31:0] frame_rd_data
);
  logic any_fault;
  logic [15:0] code_next;
  logic recov_next;
  logic rs;
  logic fpd;
  logic [31:0] state_word_next;
  logic [31:0] int_word_next;
  logic [31:0] pc_delta;
  logic in_prog_reg;
  logic halt_reg;
  logic take;
  logic [2:0] wr_ptr_reg;
  logic wr_busy_reg;
  mcf_frame_t frame_reg;
  logic [31:0] mem_wdata;

  assign rs = cpu_state.restart;
  assign fpd = cpu_state.first_part_done;
  assign any_fault = |fault_in;
  assign take = any_fault && !in_prog_reg && !halt_reg;

  // Fixed priority: bus state first since nothing after it is trustworthy
  always_comb begin
    code_next = MCF_CODE_NONE;
    recov_next = 1'b0;
    if (fault_in.bus_undef) begin
      code_next = MCF_CODE_BUS_UNDEF;
      recov_next = 1'b0;
    end else if (fault_in.wr_bus_err) begin
      code_next = MCF_CODE_WR_BUS;
      recov_next = 1'b0;
    end else if (fault_in.rd_cache_par) begin
      code_next = MCF_CODE_RD_CACHE;
      recov_next = (rs || fpd) && !cpu_state.double_error_bit;
    end else if (fault_in.rd_bus_err) begin
      code_next = MCF_CODE_RD_BUS;
      recov_next = (rs || fpd) && !cpu_state.double_error_bit;
    end else if (fault_in.bad_csaddr) begin
      code_next = MCF_CODE_BAD_CSADDR;
      recov_next = rs || fpd;
    end else if (fault_in.bad_trap) begin
      code_next = MCF_CODE_BAD_TRAP;
      recov_next = rs && !fpd;
    end else if (fault_in.strmove_bad) begin
      code_next = MCF_CODE_STRMOVE;
      recov_next = fpd;
    end else if (fault_in.unused_ipl) begin
      code_next = MCF_CODE_UNUSED_IPL;
      recov_next = rs || fpd;
    end
  end

  assign pc_delta = cpu_state.pc - cpu_state.backup_pc;

  always_comb begin
    state_word_next = MCF_WORD_RST;
    state_word_next[31:24] = pc_delta[7:0];
    state_word_next[20:18] = cpu_state.access_type_field;
    state_word_next[17:16] = cpu_state.data_length_field;
    state_word_next[15:8] = cpu_state.opcode;
    state_word_next[3:0] = cpu_state.dest_register_number;
  end

  always_comb begin
    int_word_next = MCF_WORD_RST;
    int_word_next[MCF_IE_DST_BIT] =
      cpu_state.interval_clock_ctrl[MCF_IE_SRC_BIT];
    int_word_next[15:0] = cpu_state.soft_int_summary[15:0];
  end

  // Everything is sampled on the taking edge itself
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      frame_reg <= '0;
      check_code <= MCF_CODE_NONE;
      recoverable <= 1'b0;
      va_usable <= 1'b0;
    end else if (take) begin
      frame_reg.code_word <= {rs, 15'h0000, code_next};
      frame_reg.va_word <= cpu_state.captured_virtual_address;
      frame_reg.pref_word <= cpu_state.prefetch_address_reg;
      frame_reg.int_word <= int_word_next;
      frame_reg.state_word <= state_word_next;
      check_code <= code_next;
      recoverable <= recov_next;
      va_usable <= (code_next != MCF_CODE_WR_BUS);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      check_taken <= 1'b0;
    end else begin
      check_taken <= take;
    end
  end

  // A fault in the same cycle as the clear is not taken; it sets the halt instead
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      in_prog_reg <= 1'b0;
    end else if (take) begin
      in_prog_reg <= 1'b1;
    end else if (ack_wr && ack_wdata == MCF_WORD_RST) begin
      in_prog_reg <= 1'b0;
    end
  end

  // Halt is sticky until reset; it needs the console to recover
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      halt_reg <= 1'b0;
    end else if (in_prog_reg && (any_fault || mm_exception)) begin
      halt_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    check_in_progress <= srst ? 1'b0 : (in_prog_reg || take);
    double_error_halt <= srst ? 1'b0 :
      (halt_reg || (in_prog_reg && (any_fault || mm_exception)));
  end

  assign frame_out = frame_reg;

  // Stack image writer: copies the five longwords after each capture
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr_reg <= 3'h0;
      wr_busy_reg <= 1'b0;
    end else if (take) begin
      wr_ptr_reg <= 3'h0;
      wr_busy_reg <= 1'b1;
    end else if (wr_busy_reg) begin
      if (wr_ptr_reg == 3'(MCF_FRAME_WORDS)) begin
        wr_busy_reg <= 1'b0;
      end else begin
        wr_ptr_reg <= wr_ptr_reg + 3'h1;
      end
    end
  end

  always_comb begin
    case (wr_ptr_reg)
      {1'b0, MCF_IDX_CODE}: mem_wdata = frame_reg.code_word;
      {1'b0, MCF_IDX_VA}: mem_wdata = frame_reg.va_word;
      {1'b0, MCF_IDX_PREF}: mem_wdata = frame_reg.pref_word;
      {1'b0, MCF_IDX_INT}: mem_wdata = frame_reg.int_word;
      default: mem_wdata = frame_reg.state_word;
    endcase
  end

  mcf_frame_mem #(
    .WIDTH(32),
    .DEPTH(MCF_FRAME_WORDS + 1),
    .AW(3)
  ) i_mcf_frame_mem (
    .clk_sys(clk_sys),
    .wr_en(wr_busy_reg),
    .wr_addr(wr_ptr_reg),
    .wr_data(mem_wdata),
    .rd_addr(frame_rd_idx),
    .rd_data(frame_rd_data)
  );
endmodule // mcf_check_unit

/* File: logic/mcf_pkg.sv */
package mcf_pkg;

  // Machine-check codes
  localparam logic [15:0] MCF_CODE_UNUSED_IPL = 16'h000A;
  localparam logic [15:0] MCF_CODE_STRMOVE = 16'h000B;
  localparam logic [15:0] MCF_CODE_BAD_TRAP = 16'h000C;
  localparam logic [15:0] MCF_CODE_BAD_CSADDR = 16'h000D;
  localparam logic [15:0] MCF_CODE_RD_CACHE = 16'h0010;
  localparam logic [15:0] MCF_CODE_RD_BUS = 16'h0011;
  localparam logic [15:0] MCF_CODE_WR_BUS = 16'h0012;
  localparam logic [15:0] MCF_CODE_BUS_UNDEF = 16'h0013;
  localparam logic [15:0] MCF_CODE_NONE = 16'h0000;

  // Frame longword positions
  localparam int MCF_RESTART_BIT = 31;
  localparam int MCF_IE_SRC_BIT = 6;
  localparam int MCF_IE_DST_BIT = 22;
  localparam int MCF_FRAME_WORDS = 4;
  localparam logic [1:0] MCF_IDX_CODE = 2'h0;  // (SP)+4
  localparam logic [1:0] MCF_IDX_VA = 2'h1;    // (SP)+8
  localparam logic [1:0] MCF_IDX_PREF = 2'h2;  // (SP)+12
  localparam logic [1:0] MCF_IDX_INT = 2'h3;   // (SP)+16

  // Reset values
  localparam logic [31:0] MCF_WORD_RST = 32'h0000_0000;

  // Access type and data length encodings
  typedef enum logic [2:0] {
    MCF_AT_READ = 3'h0,
    MCF_AT_WRITE = 3'h1,
    MCF_AT_MODIFY = 3'h2,
    MCF_AT_ADDRESS = 3'h5,
    MCF_AT_VARBIT = 3'h6,
    MCF_AT_BRANCH = 3'h7
  } mcf_access_t;

  typedef enum logic [1:0] {
    MCF_DL_BYTE = 2'h0,
    MCF_DL_WORD = 2'h1,
    MCF_DL_LONG = 2'h2,
    MCF_DL_QUAD = 2'h3
  } mcf_length_t;

  // Failure classes reported by the processor pipeline
  typedef struct packed {
    logic unused_ipl;
    logic strmove_bad;
    logic bad_trap;
    logic bad_csaddr;
    logic rd_cache_par;
    logic rd_bus_err;
    logic wr_bus_err;
    logic bus_undef;
  } mcf_fault_t;

  // Processor state captured on the check
  typedef struct packed {
    logic restart;
    logic first_part_done;
    logic double_error_bit;
    logic [31:0] captured_virtual_address;
    logic [31:0] prefetch_address_reg;
    logic [31:0] interval_clock_ctrl;
    logic [31:0] soft_int_summary;
    logic [31:0] pc;
    logic [31:0] backup_pc;
    mcf_access_t access_type_field;
    mcf_length_t data_length_field;
    logic [7:0] opcode;
    logic [3:0] dest_register_number;
  } mcf_cpu_state_t;

  typedef struct packed {
    logic [31:0] code_word;
    logic [31:0] va_word;
    logic [31:0] pref_word;
    logic [31:0] int_word;
    logic [31:0] state_word;
  } mcf_frame_t;

endpackage

/* File: logic/mcf_frame_mem.sv */
`timescale 1ns/1ps
module mcf_frame_mem
  import mcf_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = MCF_FRAME_WORDS + 1,
  parameter int AW = 3
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  // Refused at elaboration: the write pointer could not reach every entry
  if (DEPTH > (1 << AW) || DEPTH < 1 || WIDTH < 1) begin : g_bad_size
    $error("mcf_frame_mem: depth does not fit address width");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read keeps the frame port timing-clean
  always_ff @(posedge clk_sys) begin
    if (int'(rd_addr) < DEPTH) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= '0;
    end
  end
endmodule // mcf_frame_mem

/* File: test/mcf_check_monitor.sv */
`timescale 1ns/1ps
module mcf_check_monitor
  import mcf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire mcf_cpu_state_t cpu_state,
  input wire logic check_taken,
  input wire logic double_error_halt,
  input wire logic check_in_progress,
  input wire logic recoverable,
  input wire logic [15:0] check_code,
  input wire logic va_usable,
  input wire mcf_frame_t frame_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  code_field_a:
  assert property (check_taken |-> frame_out.code_word[15:0] == check_code)
    else $error("code field differs");
  restart_bit_a:
  assert property (check_taken |->
    frame_out.code_word[MCF_RESTART_BIT] == $past(cpu_state.restart))
    else $error("restart");
  va_capture_a:
  assert property (check_taken |-> frame_out.va_word ==
    $past(cpu_state.captured_virtual_address)) else $error("va word");
  pref_capture_a:
  assert property (check_taken |-> frame_out.pref_word ==
    $past(cpu_state.prefetch_address_reg)) else $error("prefetch word");
  spare_zero_a:
  assert property (check_taken |-> frame_out.state_word[23:21] == 3'h0 &&
    frame_out.state_word[7:4] == 4'h0) else $error("spare bits set");
  bus_fatal_a:
  assert property (check_taken && check_code == 16'h0013 |-> !recoverable)
    else $error("undefined bus recoverable");
  write_err_a:
  assert property (check_taken && check_code == 16'h0012 |->
    !recoverable && !va_usable) else $error("write error flags");
  busy_set_a:
  assert property (check_taken |-> check_in_progress ##1 !check_taken)
    else $error("in progress flag");
  halt_hold_a:
  assert property (double_error_halt |=> double_error_halt)
    else $error("halt dropped");
endmodule // mcf_check_monitor
bind mcf_check_unit mcf_check_monitor i_mcf_check_monitor (
  .clk_sys(clk_sys), .srst(srst), .cpu_state(cpu_state),
  .check_taken(check_taken), .double_error_halt(double_error_halt),
  .check_in_progress(check_in_progress), .recoverable(recoverable),
  .check_code(check_code), .va_usable(va_usable), .frame_out(frame_out));

/* File: test/mcf_check_unit_test.sv */
`timescale 1ns/1ps
module mcf_check_unit_test
  import mcf_pkg::*;
;
  logic clk_sys = 0, srst = 1, mm_exception = 0, ack_wr = 0;
  mcf_fault_t fault_in = '0;
  mcf_cpu_state_t cs = '0, snap;
  logic [31:0] ack_wdata = 0, frame_rd_data;
  logic [2:0] frame_rd_idx = 0;
  logic check_taken, halt, busy, rec, va_ok;
  logic [15:0] code;
  mcf_frame_t fo;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  logic [15:0] codes [8] = '{16'h000A, 16'h000B, 16'h000C, 16'h000D,
    16'h0010, 16'h0011, 16'h0012, 16'h0013};
  mcf_access_t ats [6] = '{MCF_AT_READ, MCF_AT_WRITE, MCF_AT_MODIFY,
    MCF_AT_ADDRESS, MCF_AT_VARBIT, MCF_AT_BRANCH};
  mcf_check_unit i_mcf_check_unit (.clk_sys(clk_sys), .srst(srst),
    .fault_in(fault_in), .mm_exception(mm_exception), .cpu_state(cs),
    .ack_wr(ack_wr), .ack_wdata(ack_wdata), .frame_rd_idx(frame_rd_idx),
    .check_taken(check_taken), .double_error_halt(halt),
    .check_in_progress(busy), .recoverable(rec), .check_code(code),
    .va_usable(va_ok), .frame_out(fo), .frame_rd_data(frame_rd_data));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      results;
    end
  end
  task chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Inputs move after the take edge so late changes must not leak in
  task take(logic [7:0] f);
    int i;
    @(negedge clk_sys);
    fault_in = f;
    snap = cs;
    @(negedge clk_sys);
    fault_in = '0;
    cs = ~cs;
    i = 0;
    while (check_taken !== 1'b1 && i < 4) begin
      @(negedge clk_sys);
      i++;
    end
    chk("taken", 1, check_taken);
  endtask
  task ack(logic [31:0] d);
    @(negedge clk_sys);
    ack_wr = 1;
    ack_wdata = d;
    @(negedge clk_sys);
    ack_wr = 0;
    ack_wdata = 0;
    repeat (3) @(negedge clk_sys);
    chk("busy", d != 0, busy);
  endtask
  function logic rec_of(int k, logic r, logic f, logic d);
    case (k)
      0, 3: return r | f;
      1: return f;
      2: return r & !f;
      4, 5: return (r | f) & !d;
      default: return 1'b0;
    endcase
  endfunction
  task t_codes;
    for (int k = 0; k < 8; k++) begin
      for (int m = 0; m < 8; m++) begin
        {cs.double_error_bit, cs.first_part_done, cs.restart} = 3'(m);
        take(8'h80 >> k);
        chk("code", codes[k], code);
        chk("rec", rec_of(k, m[0], m[1], m[2]),
          rec);
        chk("va_ok", k != 6, va_ok);
        ack(0);
      end
    end
    take(8'hFF);
    chk("prio", 16'h0013, code);
    ack(0);
    $display("test codes done");
  endtask
  task t_frame;
    for (int j = 0; j < 6; j++) begin
      cs = '0;
      cs.restart = j[0];
      cs.captured_virtual_address = 32'h1234_5670 + j;
      cs.prefetch_address_reg = 32'h89AB_CDE4 - j;
      cs.interval_clock_ctrl = j[0] ? 32'h0000_0040 : 32'hFFFF_FFBF;
      cs.soft_int_summary = 32'h5A5A_A5C3 ^ j;
      cs.pc = 32'h0000_0180 + j;
      cs.backup_pc = 32'h0000_0100;
      cs.access_type_field = ats[j];
      cs.data_length_field = mcf_length_t'(j[1:0]);
      cs.opcode = 8'hC0 + 8'(j);
      cs.dest_register_number = 4'(j + 9);
      take(8'h08);
      chk("restart", snap.restart, fo.code_word[31]);
      chk("va", snap.captured_virtual_address, fo.va_word);
      chk("pref", snap.prefetch_address_reg, fo.pref_word);
      chk("int", {snap.interval_clock_ctrl[6], snap.soft_int_summary[15:0]},
        {fo.int_word[22], fo.int_word[15:0]});
      chk("state", {8'(snap.pc - snap.backup_pc), 3'h0, ats[j],
        snap.data_length_field, snap.opcode, 4'h0,
        snap.dest_register_number},
        fo.state_word);
      repeat (7) @(negedge clk_sys);
      for (int i = 0; i < 5; i++) begin
        frame_rd_idx = 3'(i);
        @(negedge clk_sys);
        chk("mem", fo[159 - 32 * i -: 32], frame_rd_data);
      end
      ack(0);
    end
    $display("test frame done");
  endtask
  task t_nest;
    for (int m = 0; m < 2; m++) begin
      take(8'h01);
      ack(32'h0000_0001);
      @(negedge clk_sys);
      if (m == 0) fault_in = 8'h40;
      else mm_exception = 1;
      @(negedge clk_sys);
      fault_in = '0;
      mm_exception = 0;
      repeat (2) @(negedge clk_sys);
      chk("halt", 1, halt);
      srst = 1;
      repeat (3) @(negedge clk_sys);
      srst = 0;
      chk("halt_rst", 0, halt);
    end
    $display("test nest done");
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    srst = 0;
    t_codes;
    t_frame;
    t_nest;
    results;
  end
endmodule // mcf_check_unit_test
